// >>> hw/cks_pkg.sv
// Purpose: shared constants for the clock synthesizer control and status block
// Assumes: one 200 MHz clock, APB register access, one word per register
// Notes: register indices times four give the APB byte address
`default_nettype none
package cks_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // register indices
   localparam logic [IDX_W-1:0] IDX_INT_N_LOW = 10'h2a1;
   localparam logic [IDX_W-1:0] IDX_INT_N_HIGH = 10'h2a2;
   localparam logic [IDX_W-1:0] IDX_VCO_BIAS = 10'h2aa;
   localparam logic [IDX_W-1:0] IDX_VCO_CAL = 10'h2ab;
   localparam logic [IDX_W-1:0] IDX_PUMP_CUR = 10'h2ac;
   localparam logic [IDX_W-1:0] IDX_PUMP_CAL_EN = 10'h2ad;
   localparam logic [IDX_W-1:0] IDX_VARACTOR = 10'h2b7;
   localparam logic [IDX_W-1:0] IDX_REF_DIV = 10'h2bb;
   localparam logic [IDX_W-1:0] IDX_CONV_STATUS = 10'h2bc;
   localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 10'h2dc;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h300;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h301;

   // reset values
   localparam logic [REG_W-1:0] RST_INT_N_LOW = 8'h80;
   localparam logic [REG_W-1:0] RST_INT_N_HIGH = 8'h00;
   localparam logic [REG_W-1:0] RST_VCO_BIAS = 8'h37;
   localparam logic [REG_W-1:0] RST_VCO_CAL = 8'hc0;
   localparam logic [REG_W-1:0] RST_PUMP_CUR = 8'h19;
   localparam logic [REG_W-1:0] RST_PUMP_CAL_EN = 8'h00;
   localparam logic [REG_W-1:0] RST_VARACTOR = 8'hd0;
   localparam logic [REG_W-1:0] RST_REF_DIV = 8'hb9;
   localparam logic [3:0] STATUS_UPPER = 4'h8;

   // field positions
   localparam int INT_N_HIGH_W = 3;
   localparam int INT_N_W = 11;
   localparam int BIAS_TEMPCO_HI = 5;
   localparam int BIAS_TEMPCO_LO = 4;
   localparam int BIAS_HI = 2;
   localparam int BIAS_LO = 0;
   localparam int INIT_LEVEL_HI = 7;
   localparam int INIT_LEVEL_LO = 4;
   localparam int LEVEL_TEST_BIT = 3;
   localparam int CAL_START_BIT = 0;
   localparam int PUMP_CUR_HI = 5;
   localparam int PUMP_CUR_LO = 0;
   localparam int PUMP_CAL_EN_HI = 7;
   localparam int PUMP_CAL_EN_LO = 6;
   localparam int VARACTOR_HI = 7;
   localparam int VARACTOR_LO = 4;
   localparam int REF_DIV_HI = 7;
   localparam int REF_DIV_LO = 6;
   localparam int SAMPLE_SEL_BIT = 3;
   localparam int TERM_SEL_BIT = 2;
   localparam int ST_LOCK_BIT = 3;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_CP_DONE_BIT = 0;

   // reference divider codes
   localparam logic [1:0] REF_DIV1 = 2'h0;
   localparam logic [1:0] REF_DIV2 = 2'h1;
   localparam logic [1:0] REF_DIV4 = 2'h2;
   localparam logic [1:0] REF_MUL2 = 2'h3;

   // interrupt event bits
   localparam int IRQ_W = 4;
   localparam int EV_CONV_CAL_DONE = 0;
   localparam int EV_LINK_CAL_DONE = 1;
   localparam int EV_CONV_LOCK_LOST = 2;
   localparam int EV_LINK_LOCK_LOST = 3;

   // calibration timing
   localparam int VCO_CAL_TIME_NS = 2000;
   localparam int PUMP_CAL_TIME_NS = 1000;
   localparam int VCO_CAL_CYCLES = (VCO_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PUMP_CAL_CYCLES = (PUMP_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;

   typedef enum logic [1:0] {
      CKS_IDLE = 2'b00,
      CKS_VCO = 2'b01,
      CKS_PUMP = 2'b10
   } cks_cal_state_e;
endpackage : cks_pkg
`default_nettype wire

// >>> hw/cks_cal_seq.sv
// Purpose: timed VCO calibration followed by optional charge-pump calibration
// Assumes: start is a one-cycle pulse; starts while busy are ignored
// Notes: one instance per synthesizer
`default_nettype none
module cks_cal_seq #(
   parameter int VCO_CYCLES = cks_pkg::VCO_CAL_CYCLES,
   parameter int PUMP_CYCLES = cks_pkg::PUMP_CAL_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_pump_en,
   output logic o_busy,
   output logic o_pump_done,
   output logic o_done
);
   import cks_pkg::*;

   localparam logic [CNT_W-1:0] VCO_LAST = CNT_W'(VCO_CYCLES - 1);
   localparam logic [CNT_W-1:0] PUMP_LAST = CNT_W'(PUMP_CYCLES - 1);
   localparam int BUSY_LIM = VCO_CYCLES + 2;

   cks_cal_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic pump_done_reg, pump_done_next;
   logic done_reg, done_next;

   wire logic vco_end = (state_reg == CKS_VCO) && (cnt_reg == VCO_LAST);
   wire logic pump_end = (state_reg == CKS_PUMP) && (cnt_reg == PUMP_LAST);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + CNT_W'(1);
      pump_done_next = pump_done_reg;
      done_next = 1'b0;
      case (state_reg)
         CKS_IDLE: begin
            cnt_next = '0;
            if (i_start) begin
               state_next = CKS_VCO;
               pump_done_next = 1'b0;
            end
         end
         CKS_VCO: begin
            if (vco_end) begin
               cnt_next = '0;
               done_next = 1'b1;
               state_next = i_pump_en ? CKS_PUMP : CKS_IDLE;
            end
         end
         CKS_PUMP: begin
            // status shows not busy here, so a new start must not be lost
            if (i_start) begin
               state_next = CKS_VCO;
               cnt_next = '0;
               pump_done_next = 1'b0;
            end else if (pump_end) begin
               state_next = CKS_IDLE;
               pump_done_next = 1'b1;
            end
         end
         default: begin
            state_next = CKS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= CKS_IDLE;
         cnt_reg <= '0;
         pump_done_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pump_done_reg <= pump_done_next;
         done_reg <= done_next;
      end
   end

   // busy is the state itself so it rises the cycle after start is taken
   assign o_busy = (state_reg == CKS_VCO);
   assign o_pump_done = pump_done_reg;
   assign o_done = done_reg;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_launch;
      i_start && (state_reg != CKS_VCO);
   endsequence

   sequence s_busy_run;
      o_busy [*2];
   endsequence

   AST_BUSY_START: assert property (@(posedge i_clk) disable iff (i_rst)
      s_launch |=> s_busy_run)
      else $error("busy did not rise after calibration start");

   AST_BUSY_ENDS: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_busy) |-> ##[1:BUSY_LIM] !o_busy)
      else $error("calibration busy never cleared");

   AST_PUMP_DONE_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
      s_launch |=> !o_pump_done)
      else $error("pump done not cleared on new calibration");
endmodule : cks_cal_seq
`default_nettype wire

// >>> hw/cks_top.sv
// Purpose: control and status registers of the converter clock synthesizer
// Assumes: APB slave, no wait states on any access, lock inputs synchronous
// Notes: register byte address is four times its index
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module cks_top #(
   parameter int VCO_CYCLES = cks_pkg::VCO_CAL_CYCLES,
   parameter int PUMP_CYCLES = cks_pkg::PUMP_CAL_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [cks_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [cks_pkg::DATA_W-1:0] i_pwdata,
   output logic o_pready,
   output logic [cks_pkg::DATA_W-1:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_conv_lock,
   input wire logic i_link_lock,
   input wire logic i_link_cal_start,
   input wire logic i_link_pump_cal_en,
   output logic [1:0] o_ref_div_code,
   output logic [1:0] o_ref_div_log2,
   output logic o_ref_mult2,
   output logic o_sample_clk_sel,
   output logic o_term_sel,
   output logic [1:0] o_bias_tempco,
   output logic [2:0] o_bias,
   output logic [3:0] o_init_level,
   output logic o_level_test,
   output logic [5:0] o_pump_current,
   output logic [1:0] o_pump_cal_en,
   output logic [3:0] o_varactor,
   output logic [cks_pkg::INT_N_W-1:0] o_int_n,
   output logic o_irq
);
   import cks_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   logic [REG_W-1:0] int_n_low_reg, int_n_high_reg, vco_bias_reg, vco_cal_reg;
   logic [REG_W-1:0] pump_cur_reg, pump_cal_en_reg, varactor_reg, ref_div_reg;
   logic [IRQ_W-1:0] irq_status_reg, irq_mask_reg, irq_status_next;
   logic [DATA_W-1:0] prdata_reg, rd_mux;
   logic pready_reg, pslverr_reg, irq_reg;
   logic conv_lock_reg, link_lock_reg;
   logic [1:0] ref_div_log2_reg, ref_div_log2_next;
   logic ref_mult2_reg;

   wire logic [IDX_W-1:0] idx = i_paddr[ADDR_W-1:2];
   wire logic aligned = (i_paddr[1:0] == 2'h0);
   wire logic setup = i_psel && !i_penable;
   wire logic access_end = i_psel && i_penable && pready_reg;
   wire logic wr = access_end && i_pwrite && aligned;
   wire logic [REG_W-1:0] wbyte = i_pwdata[REG_W-1:0];
   wire logic [IRQ_W-1:0] wirq = i_pwdata[IRQ_W-1:0];

   wire logic hit_int_lo = aligned && (idx == IDX_INT_N_LOW);
   wire logic hit_int_hi = aligned && (idx == IDX_INT_N_HIGH);
   wire logic hit_bias = aligned && (idx == IDX_VCO_BIAS);
   wire logic hit_cal = aligned && (idx == IDX_VCO_CAL);
   wire logic hit_pcur = aligned && (idx == IDX_PUMP_CUR);
   wire logic hit_pcen = aligned && (idx == IDX_PUMP_CAL_EN);
   wire logic hit_var = aligned && (idx == IDX_VARACTOR);
   wire logic hit_rdiv = aligned && (idx == IDX_REF_DIV);
   wire logic hit_cst = aligned && (idx == IDX_CONV_STATUS);
   wire logic hit_lst = aligned && (idx == IDX_LINK_STATUS);
   wire logic hit_ist = aligned && (idx == IDX_IRQ_STATUS);
   wire logic hit_imsk = aligned && (idx == IDX_IRQ_MASK);
   wire logic mapped = hit_int_lo || hit_int_hi || hit_bias || hit_cal || hit_pcur
      || hit_pcen || hit_var || hit_rdiv || hit_cst || hit_lst || hit_ist || hit_imsk;
   // converter and link status registers are read only, writing them is flagged as an error
   wire logic bad = !mapped || (i_pwrite && (hit_cst || hit_lst));

   wire logic cal_start = wr && hit_cal && wbyte[CAL_START_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // calibration sequencers
   logic conv_busy, conv_pump_done, conv_done;
   logic link_busy, link_pump_done, link_done;

   cks_cal_seq #(
      .VCO_CYCLES(VCO_CYCLES),
      .PUMP_CYCLES(PUMP_CYCLES)
   ) u_conv_cal (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(cal_start),
      .i_pump_en(|pump_cal_en_reg[PUMP_CAL_EN_HI:PUMP_CAL_EN_LO]),
      .o_busy(conv_busy),
      .o_pump_done(conv_pump_done),
      .o_done(conv_done)
   );

   cks_cal_seq #(
      .VCO_CYCLES(VCO_CYCLES),
      .PUMP_CYCLES(PUMP_CYCLES)
   ) u_link_cal (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(i_link_cal_start),
      .i_pump_en(i_link_pump_cal_en),
      .o_busy(link_busy),
      .o_pump_done(link_pump_done),
      .o_done(link_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status words
   wire logic [REG_W-1:0] conv_status = {STATUS_UPPER, conv_lock_reg, 1'b0, conv_busy,
      conv_pump_done};
   wire logic [REG_W-1:0] link_status = {STATUS_UPPER, link_lock_reg, 1'b0, link_busy,
      link_pump_done};

   assign rd_mux = hit_int_lo ? DATA_W'(int_n_low_reg) :
      hit_int_hi ? DATA_W'(int_n_high_reg) :
      hit_bias ? DATA_W'(vco_bias_reg) :
      hit_cal ? DATA_W'(vco_cal_reg) :
      hit_pcur ? DATA_W'(pump_cur_reg) :
      hit_pcen ? DATA_W'(pump_cal_en_reg) :
      hit_var ? DATA_W'(varactor_reg) :
      hit_rdiv ? DATA_W'(ref_div_reg) :
      hit_cst ? DATA_W'(conv_status) :
      hit_lst ? DATA_W'(link_status) :
      hit_ist ? DATA_W'(irq_status_reg) :
      hit_imsk ? DATA_W'(irq_mask_reg) : '0;

   // events: VCO calibration phase finished, lock lost
   wire logic [IRQ_W-1:0] events = {
      link_lock_reg && !i_link_lock,
      conv_lock_reg && !i_conv_lock,
      link_done,
      conv_done};
   // a new event wins over a write-one clear in the same cycle
   assign irq_status_next = (irq_status_reg & ~((wr && hit_ist) ? wirq : '0)) | events;

   wire logic [1:0] rdiv_code_next = ref_div_reg[REF_DIV_HI:REF_DIV_LO];
   assign ref_div_log2_next = (rdiv_code_next == REF_DIV2) ? 2'h1 :
      (rdiv_code_next == REF_DIV4) ? 2'h2 : 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // apb response, pready registered from setup so no wait state and every output leaves a flop
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= setup;
         if (setup) begin
            prdata_reg <= i_pwrite ? '0 : rd_mux;
            pslverr_reg <= bad;
         end
      end
   end

   // control registers; reserved bits are kept as written
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         int_n_low_reg <= RST_INT_N_LOW;
         int_n_high_reg <= RST_INT_N_HIGH;
         vco_bias_reg <= RST_VCO_BIAS;
         vco_cal_reg <= RST_VCO_CAL;
         pump_cur_reg <= RST_PUMP_CUR;
         pump_cal_en_reg <= RST_PUMP_CAL_EN;
         varactor_reg <= RST_VARACTOR;
         ref_div_reg <= RST_REF_DIV;
      end else if (wr) begin
         if (hit_int_lo) int_n_low_reg <= wbyte;
         if (hit_int_hi) int_n_high_reg <= wbyte;
         if (hit_bias) vco_bias_reg <= wbyte;
         if (hit_cal) vco_cal_reg <= wbyte;
         if (hit_pcur) pump_cur_reg <= wbyte;
         if (hit_pcen) pump_cal_en_reg <= wbyte;
         if (hit_var) varactor_reg <= wbyte;
         if (hit_rdiv) ref_div_reg <= wbyte;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_status_reg <= '0;
         irq_mask_reg <= '0;
         irq_reg <= 1'b0;
         conv_lock_reg <= 1'b0;
         link_lock_reg <= 1'b0;
         ref_div_log2_reg <= 2'h2;
         ref_mult2_reg <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         if (wr && hit_imsk) irq_mask_reg <= wirq;
         irq_reg <= |(irq_status_next & irq_mask_reg);
         conv_lock_reg <= i_conv_lock;
         link_lock_reg <= i_link_lock;
         ref_div_log2_reg <= ref_div_log2_next;
         ref_mult2_reg <= (rdiv_code_next == REF_MUL2);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign o_pready = pready_reg;
   assign o_prdata = prdata_reg;
   assign o_pslverr = pslverr_reg;
   assign o_irq = irq_reg;
   assign o_ref_div_code = ref_div_reg[REF_DIV_HI:REF_DIV_LO];
   assign o_ref_div_log2 = ref_div_log2_reg;
   assign o_ref_mult2 = ref_mult2_reg;
   assign o_sample_clk_sel = ref_div_reg[SAMPLE_SEL_BIT];
   assign o_term_sel = ref_div_reg[TERM_SEL_BIT];
   assign o_bias_tempco = vco_bias_reg[BIAS_TEMPCO_HI:BIAS_TEMPCO_LO];
   assign o_bias = vco_bias_reg[BIAS_HI:BIAS_LO];
   assign o_init_level = vco_cal_reg[INIT_LEVEL_HI:INIT_LEVEL_LO];
   assign o_level_test = vco_cal_reg[LEVEL_TEST_BIT];
   assign o_pump_current = pump_cur_reg[PUMP_CUR_HI:PUMP_CUR_LO];
   assign o_pump_cal_en = pump_cal_en_reg[PUMP_CAL_EN_HI:PUMP_CAL_EN_LO];
   assign o_varactor = varactor_reg[VARACTOR_HI:VARACTOR_LO];
   assign o_int_n = {int_n_high_reg[INT_N_HIGH_W-1:0], int_n_low_reg};

   ////////////////////////////////////////////////////////////////////////////
   sequence s_rd_setup(logic hit);
      setup && !i_pwrite && hit;
   endsequence

   AST_REF_MULT: assert property (@(posedge i_clk) disable iff (i_rst)
      ##1 (o_ref_mult2 == ($past(o_ref_div_code) == REF_MUL2)))
      else $error("multiply flag does not follow divider code");

   AST_REF_DIV4: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_ref_div_code == REF_DIV4) [*2] |-> (o_ref_div_log2 == 2'h2) && !o_ref_mult2)
      else $error("divide by four code not decoded");

   AST_SAMPLE_RESET: assert property (@(posedge i_clk)
      !i_rst && $past(i_rst) |-> o_sample_clk_sel && (o_ref_div_code == REF_DIV4))
      else $error("sample clock select or divider wrong after reset");

   AST_TERM_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr && hit_rdiv) |=> (o_term_sel == $past(i_pwdata[TERM_SEL_BIT])))
      else $error("termination select did not take write");

   AST_CAL_RESET: assert property (@(posedge i_clk)
      !i_rst && $past(i_rst) |-> (o_init_level == 4'hc) && !o_level_test)
      else $error("calibration fields wrong after reset");

   AST_CONV_LOCK_READ: assert property (@(posedge i_clk) disable iff (i_rst)
      s_rd_setup(hit_cst) |=> (o_prdata[ST_LOCK_BIT] == $past(conv_lock_reg)))
      else $error("converter lock bit misread");

   AST_BUSY_READ: assert property (@(posedge i_clk) disable iff (i_rst)
      s_rd_setup(hit_cst) |=> (o_prdata[ST_BUSY_BIT] == $past(conv_busy)))
      else $error("busy bit misread");

   AST_PUMP_READ: assert property (@(posedge i_clk) disable iff (i_rst)
      s_rd_setup(hit_cst) |=> (o_prdata[ST_CP_DONE_BIT] == $past(conv_pump_done)))
      else $error("pump done bit misread");

   AST_LINK_UPPER: assert property (@(posedge i_clk) disable iff (i_rst)
      s_rd_setup(hit_lst) |=> (o_prdata[REG_W-1:0] == $past(link_status))
         && (o_prdata[7:4] == STATUS_UPPER))
      else $error("link status misread");

   AST_BIAS_RESET: assert property (@(posedge i_clk)
      !i_rst && $past(i_rst) |-> (o_bias_tempco == 2'h3) && (o_bias == 3'h7))
      else $error("bias fields wrong after reset");

   AST_INT_N_HIGH: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr && hit_int_hi) |=> (o_int_n[INT_N_W-1:REG_W] == $past(i_pwdata[2:0])))
      else $error("integer divide high bits not stored");

   AST_START_BUSY: assert property (@(posedge i_clk) disable iff (i_rst)
      (cal_start && !conv_busy) |=> conv_busy)
      else $error("start write did not raise busy");

   AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (i_rst)
      ##1 (o_irq == $past(|(irq_status_next & irq_mask_reg))))
      else $error("interrupt output does not follow masked status");

   AST_IRQ_SET_WINS: assert property (@(posedge i_clk) disable iff (i_rst)
      (|events) |=> ((irq_status_reg & $past(events)) == $past(events)))
      else $error("event lost against a clear");

   // bus handshake and converter status upper nibble
   AST_PREADY_SETUP: assert property (@(posedge i_clk) disable iff (i_rst)
      setup |=> o_pready)
      else $error("pready missing after setup");

   AST_PREADY_ONE: assert property (@(posedge i_clk) disable iff (i_rst)
      o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");

   AST_UNMAPPED_ERR: assert property (@(posedge i_clk) disable iff (i_rst)
      (setup && !mapped) |=> o_pslverr)
      else $error("unmapped access not flagged");

   AST_STATUS_WR_ERR: assert property (@(posedge i_clk) disable iff (i_rst)
      (setup && i_pwrite && hit_cst) |=> o_pslverr && (o_prdata == '0))
      else $error("status write not refused");

   AST_CONV_UPPER: assert property (@(posedge i_clk) disable iff (i_rst)
      s_rd_setup(hit_cst) |=> (o_prdata[REG_W-1:REG_W-4] == STATUS_UPPER))
      else $error("converter status upper nibble wrong");

   // register fields
   AST_SAMPLE_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr && hit_rdiv) |=> (o_sample_clk_sel == $past(i_pwdata[SAMPLE_SEL_BIT])))
      else $error("sample clock select did not take write");

   AST_TERM_RESET: assert property (@(posedge i_clk)
      !i_rst && $past(i_rst) |-> !o_term_sel)
      else $error("termination select wrong after reset");

   AST_LEVEL_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr && hit_cal) |=> (o_init_level == $past(i_pwdata[INIT_LEVEL_HI:INIT_LEVEL_LO])))
      else $error("initial level did not take write");

   AST_BIAS_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr && hit_bias) |=> (o_bias == $past(i_pwdata[BIAS_HI:BIAS_LO])))
      else $error("bias did not take write");

   AST_INT_N_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr && hit_int_lo) |=> (o_int_n[REG_W-1:0] == $past(i_pwdata[REG_W-1:0])))
      else $error("integer divide low bits not stored");

   AST_DIV1_DECODE: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_ref_div_code == REF_DIV1) [*2] |-> (o_ref_div_log2 == 2'h0) && !o_ref_mult2)
      else $error("divide by one code not decoded");

   AST_DIV2_DECODE: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_ref_div_code == REF_DIV2) [*2] |-> (o_ref_div_log2 == 2'h1) && !o_ref_mult2)
      else $error("divide by two code not decoded");
endmodule : cks_top
`default_nettype wire

// >>> test/tb_cks_top.sv
// Purpose: self-checking bench for the clock synthesizer control and status registers
// Assumes: APB master driven on rising edges; short calibration timers
// Notes: expected values come from the register table and the package constants
`default_nettype none
module tb_cks_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cks_pkg::*;
   localparam int VCO_N = 8;
   localparam int PUMP_N = 4;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [ADDR_W-1:0] i_paddr = '0;
   logic [DATA_W-1:0] i_pwdata = '0;
   logic i_conv_lock = 1'b0;
   logic i_link_lock = 1'b0;
   logic i_link_cal_start = 1'b0;
   logic i_link_pump_cal_en = 1'b0;
   logic o_pready, o_pslverr, o_ref_mult2, o_sample_clk_sel, o_term_sel, o_level_test, o_irq;
   logic [DATA_W-1:0] o_prdata;
   logic [1:0] o_ref_div_code, o_ref_div_log2, o_bias_tempco, o_pump_cal_en;
   logic [2:0] o_bias;
   logic [3:0] o_init_level, o_varactor;
   logic [5:0] o_pump_current;
   logic [INT_N_W-1:0] o_int_n;
   logic [31:0] rdata;
   logic rerr;
   int failures = 0;
   int samples_checked = 0;

   always #2.5 i_clk = ~i_clk;

   cks_top #(.VCO_CYCLES(VCO_N), .PUMP_CYCLES(PUMP_N)) cks_top_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
      .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_conv_lock(i_conv_lock),
      .i_link_lock(i_link_lock), .i_link_cal_start(i_link_cal_start),
      .i_link_pump_cal_en(i_link_pump_cal_en), .o_ref_div_code(o_ref_div_code),
      .o_ref_div_log2(o_ref_div_log2), .o_ref_mult2(o_ref_mult2),
      .o_sample_clk_sel(o_sample_clk_sel), .o_term_sel(o_term_sel),
      .o_bias_tempco(o_bias_tempco), .o_bias(o_bias), .o_init_level(o_init_level),
      .o_level_test(o_level_test), .o_pump_current(o_pump_current),
      .o_pump_cal_en(o_pump_cal_en), .o_varactor(o_varactor), .o_int_n(o_int_n), .o_irq(o_irq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one transfer; data and error are taken at the rising edge with pready high, then released
   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
      int n;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= {idx, 2'b00};
      i_pwdata <= {24'h0, d};
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         $display("wrong value pready expected 1 seen 0");
      end
      rdata = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input string nm, input logic [IDX_W-1:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(nm, rdata, {24'h0, e});
   endtask : rd_chk

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge i_clk);
      failures++;
      summarize();
   end

   initial begin
      logic [IDX_W-1:0] idx_t[10];
      logic [7:0] rst_t[10];
      idx_t = '{IDX_INT_N_LOW, IDX_INT_N_HIGH, IDX_VCO_BIAS, IDX_VCO_CAL, IDX_PUMP_CUR,
                IDX_PUMP_CAL_EN, IDX_VARACTOR, IDX_REF_DIV, IDX_CONV_STATUS, IDX_LINK_STATUS};
      rst_t = '{8'h80, 8'h00, 8'h37, 8'hc0, 8'h19, 8'h00, 8'hd0, 8'hb9, 8'h80, 8'h80};
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rd_chk("reset value", idx_t[i], rst_t[i]);
      end
      chk("reset decode", {o_ref_div_log2, o_ref_mult2, o_sample_clk_sel, o_term_sel},
          5'h12);
      chk("varactor reset", o_varactor, 4'hd);
      $display("test reset values done");
      // every divider code, with select and termination bits walking through all pairs
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, IDX_REF_DIV, {c[1:0], 2'h3, c[0], c[1], 2'h1});
         repeat (2) @(negedge i_clk);
         chk("ref div decode", {o_ref_div_code, o_ref_div_log2, o_ref_mult2},
             {c[1:0], (c == 3) ? 2'h0 : c[1:0], c == 3});
         chk("sample and termination", {o_sample_clk_sel, o_term_sel}, {c[0], c[1]});
         rd_chk("ref div readback", IDX_REF_DIV, {c[1:0], 2'h3, c[0], c[1], 2'h1});
      end
      $display("test reference divider done");
      apb(1'b1, IDX_VCO_BIAS, 8'h25);
      apb(1'b1, IDX_VCO_CAL, 8'ha8);
      apb(1'b1, IDX_PUMP_CUR, 8'h3f);
      apb(1'b1, IDX_INT_N_LOW, 8'h5a);
      apb(1'b1, IDX_INT_N_HIGH, 8'h05);
      repeat (2) @(negedge i_clk);
      chk("bias fields", {o_bias_tempco, o_bias}, 5'h15);
      chk("cal fields", {o_init_level, o_level_test}, 5'h15);
      chk("pump current", o_pump_current, 6'h3f);
      chk("integer divide", o_int_n, 11'h55a);
      apb(1'b1, IDX_CONV_STATUS, 8'h0f);
      chk("status write error", rerr, 1'b1);
      apb(1'b0, 10'h001, 8'h00);
      chk("unmapped error", rerr, 1'b1);
      rd_chk("status unchanged", IDX_CONV_STATUS, 8'h80);
      $display("test fields and refusals done");
      i_conv_lock <= 1'b1;
      i_link_lock <= 1'b1;
      rd_chk("conv lock", IDX_CONV_STATUS, 8'h88);
      rd_chk("link lock", IDX_LINK_STATUS, 8'h88);
      // converter calibration with the pump phase enabled
      apb(1'b1, IDX_IRQ_MASK, 8'h0f);
      apb(1'b1, IDX_PUMP_CAL_EN, 8'hc0);
      apb(1'b1, IDX_VCO_CAL, 8'hc1);
      rd_chk("conv busy", IDX_CONV_STATUS, 8'h8a);
      repeat (VCO_N + PUMP_N + 4) @(posedge i_clk);
      rd_chk("conv cal done", IDX_CONV_STATUS, 8'h89);
      chk("irq raised", o_irq, 1'b1);
      chk("pump cal enable", o_pump_cal_en, 2'h3);
      rd_chk("irq status", IDX_IRQ_STATUS, 8'h01);
      apb(1'b1, IDX_IRQ_STATUS, 8'h01);
      repeat (2) @(negedge i_clk);
      chk("irq cleared", o_irq, 1'b0);
      $display("test converter calibration done");
      // link calibration without the pump phase, then a masked event
      apb(1'b1, IDX_IRQ_MASK, 8'h00);
      i_link_cal_start <= 1'b1;
      @(posedge i_clk);
      i_link_cal_start <= 1'b0;
      rd_chk("link busy", IDX_LINK_STATUS, 8'h8a);
      repeat (VCO_N + PUMP_N + 4) @(posedge i_clk);
      rd_chk("link cal done", IDX_LINK_STATUS, 8'h88);
      chk("irq masked", o_irq, 1'b0);
      i_conv_lock <= 1'b0;
      repeat (3) @(posedge i_clk);
      rd_chk("lock lost events", IDX_IRQ_STATUS, 8'h06);
      rd_chk("conv unlocked", IDX_CONV_STATUS, 8'h81);
      apb(1'b1, IDX_IRQ_MASK, 8'h04);
      repeat (2) @(negedge i_clk);
      chk("irq unmasked", o_irq, 1'b1);
      $display("test link calibration and lock loss done");
      summarize();
   end
endmodule : tb_cks_top
`default_nettype wire
